// File: logic/servo_cfg.svh
// Constants of the servo serial command handler
`ifndef SERVO_CFG_SVH
`define SERVO_CFG_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define A_CMD       8'h00
`define A_WDATA     8'h04
`define A_STATUS    8'h08
`define A_RDATA     8'h0C
`define A_RINFO     8'h10
`define A_EE_WRITES 8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_DNUM      7:0
`define F_CODE      15:8
`define F_MODE      31:28
`define F_DP        27:24
`define F_VAL       23:0
`define F_LOCK      3:0
`define B_BUSY      0
`define B_DONE      1
`define B_ERR       2
`define F_RI_DP     3:0
`define F_RI_TYPE   7:4
`define B_RI_DIS    8
`define F_ST_DP     35:32
// ----------------------------------------
// Command codes and data numbers
// ----------------------------------------
`define CMD_STAT_RD  8'h01
`define CMD_PARAM_RD 8'h05
`define CMD_PIN_RD   8'h12
`define CMD_STAT_CLR 8'h81
`define CMD_PARAM_WR 8'h84
`define DNUM_FB      8'h80
`define DNUM_CLR     8'h00
`define DNUM_IN      8'h40
`define DNUM_OUT     8'hC0
`define DNUM_PMAX    8'h54
`define CLR_KEY      32'h0000_1EA5
// ----------------------------------------
// Parameter store and data formats
// ----------------------------------------
`define PARAM_COUNT   85
`define INHIBIT_PARAM 7'h13
`define PARAM_HEX_MASK 85'h8_0003
`define WMODE_EE      4'h0
`define WMODE_RAM     4'h3
`define DP_NONE       4'h0
`define DP_MAX        4'h5
`define TYPE_DEC      4'h0
`define TYPE_HEX      4'h1
`define IN_PINS       9
`define OUT_PINS      7
`define SYNC_W        17
`define SYNC_FB       16
`endif

// File: logic/servo_pkg.sv
// Types shared by the servo serial command handler
`include "servo_cfg.svh"
package servo_pkg;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_EXEC  = 3'b010,
    S_FETCH = 3'b100
  } fsm_t;

  typedef struct packed {
    fsm_t        fsm;
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  code;
    logic [7:0]  dnum;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0]  rtype;
    logic [3:0]  rdp;
    logic        rdis;
    logic        busy;
    logic        done;
    logic        err;
    logic [31:0] fb_cnt;
    logic        fb_prev;
    logic [31:0] ee_cnt;
    logic        st_we;
    logic [6:0]  st_addr;
    logic [35:0] st_word;
  } hdl_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] s1;
    logic [`SYNC_W-1:0] s2;
  } sync_t;

  typedef struct packed {
    logic [35:0] rword;
    logic [31:0] lock;
  } store_t;
endpackage

// File: logic/pin_sync.sv
// Two-stage synchroniser for the pin inputs
`include "servo_cfg.svh"
module pin_sync
  import servo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [`SYNC_W-1:0] din,
  output logic      [`SYNC_W-1:0] dout
);
  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s    = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.s2;
endmodule

// File: logic/param_store.sv
// Parameter memory with write-inhibit copy
`include "servo_cfg.svh"
module param_store
  import servo_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        we,
  input  wire logic [6:0]  waddr,
  input  wire logic [35:0] wword,
  input  wire logic [6:0]  raddr,
  output logic      [35:0] rword,
  output logic      [31:0] lock_word
);
  // Memory is not cleared by reset; write a parameter before reading it
  logic [35:0] mem [0:`PARAM_COUNT-1];
  store_t      s;
  store_t      next_s;

  always_comb begin
    next_s       = s;
    next_s.rword = mem[raddr];
    if (we && waddr == `INHIBIT_PARAM) begin
      next_s.lock = wword[31:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wword;
    end
  end

  assign rword     = s.rword;
  assign lock_word = s.lock;
endmodule

// File: logic/servo_cmd_handler.sv
// Serial command handler of the servo amplifier, Wishbone register front end
//
// Implementation choices: the placing of the registers and the Wishbone register port.
`include "servo_cfg.svh"
// Summary of operation
// - Every command plus data number gets an answer; a command written while busy is dropped unanswered
// - Decimal write needs point position, else rejected
// - Point position 0 none, 1..5 lowest digits
// - Command 01 returns status item with format
// - Command 81/00/1EA5 zeroes cumulative feedback pulses
// - Command 05, numbers 00..54 read parameters
// - Parameter 19 inhibit flags reads as disabled
// - Command 84 stores set data into parameter
// - Write mode 0 EEPROM, 3 RAM only
// - Command 12 number 40 reads input pins
// - Input pins sent as bits 0..8
// - Command 12 number C0 reads output pins
// - Output pins sent as bits 0..6
module servo_cmd_handler
  import servo_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  input  wire logic                 CYC_I,
  input  wire logic                 STB_I,
  input  wire logic                 WE_I,
  input  wire logic [7:0]           ADR_I,
  input  wire logic [3:0]           SEL_I,
  input  wire logic [31:0]          DAT_I,
  output logic      [31:0]          DAT_O,
  output logic                      ACK_O,
  input  wire logic [`IN_PINS-1:0]  IN_PIN,
  input  wire logic [`OUT_PINS-1:0] OUT_PIN,
  input  wire logic                 FB_PULSE
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  hdl_t               s;
  hdl_t               next_s;
  logic [`SYNC_W-1:0] pins;
  logic [35:0]        st_rword;
  logic [31:0]        lock_word;
  logic [31:0]        in_word;
  logic [31:0]        out_word;
  logic [31:0]        cmd_word;
  logic               fb_edge;
  logic               fb_clear;
  logic [3:0]         wmode;
  logic [3:0]         wdp;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Data numbers above the top parameter are refused
  function automatic logic param_ok(input logic [7:0] dnum);
    return dnum <= `DNUM_PMAX;
  endfunction

  // Hex parameters take no decimal point on write
  function automatic logic param_hex(input logic [6:0] idx);
    logic [`PARAM_COUNT-1:0] mask;
    mask = `PARAM_HEX_MASK;
    return mask[idx];
  endfunction

  // ----------------------------------------
  // Pin synchronisers and parameter memory
  // ----------------------------------------
  pin_sync u_sync (
    .clk  (SYS_CLK),
    .nrst (NRST),
    .din  ({FB_PULSE, OUT_PIN, IN_PIN}),
    .dout (pins)
  );

  param_store u_store (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .we        (s.st_we),
    .waddr     (s.st_addr),
    .wword     (s.st_word),
    .raddr     (s.dnum[6:0]),
    .rword     (st_rword),
    .lock_word (lock_word)
  );

  // ----------------------------------------
  // Pin status words
  // ----------------------------------------
  // Unused positions stay zero; padding is explicit
  generate
    for (genvar b = 0; b < 32; b++) begin : g_pinmap
      if (b < `IN_PINS) begin : g_in
        assign in_word[b] = pins[b];
      end else begin : g_in0
        assign in_word[b] = 1'b0;
      end
      if (b < `OUT_PINS) begin : g_out
        assign out_word[b] = pins[`IN_PINS + b];
      end else begin : g_out0
        assign out_word[b] = 1'b0;
      end
    end
  endgenerate

  assign cmd_word = merge({16'h0000, s.code, s.dnum}, DAT_I, SEL_I);
  assign wmode    = s.wdata[`F_MODE];
  assign wdp      = s.wdata[`F_DP];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_s         = s;
    next_s.st_we   = 1'b0;
    fb_edge        = pins[`SYNC_FB] & ~s.fb_prev;
    fb_clear       = 1'b0;
    next_s.fb_prev = pins[`SYNC_FB];

    // ----------------------------------------
    // Bus front end
    // ----------------------------------------
    // Wishbone classic: one wait state, ack dropped after one cycle
    next_s.ack = CYC_I & STB_I & ~s.ack;
    if (CYC_I && STB_I && !s.ack) begin
      if (WE_I) begin
        case (ADR_I)
          `A_CMD: begin
            // A command arriving while busy is dropped; poll busy first
            if (!s.busy) begin
              next_s.code = cmd_word[`F_CODE];
              next_s.dnum = cmd_word[`F_DNUM];
              next_s.busy = 1'b1;
              next_s.done = 1'b0;
              next_s.err  = 1'b0;
              next_s.fsm  = S_EXEC;
            end
          end
          `A_WDATA: next_s.wdata = merge(s.wdata, DAT_I, SEL_I);
          default: ;
        endcase
      end else begin
        // Read data is registered so DAT_O comes straight from a flop
        case (ADR_I)
          `A_CMD:       next_s.dat = {16'h0000, s.code, s.dnum};
          `A_WDATA:     next_s.dat = s.wdata;
          `A_STATUS:    next_s.dat = {29'h0, s.err, s.done, s.busy};
          `A_RDATA:     next_s.dat = s.rdata;
          `A_RINFO:     next_s.dat = {23'h0, s.rdis, s.rtype, s.rdp};
          `A_EE_WRITES: next_s.dat = s.ee_cnt;
          default:      next_s.dat = 32'h0000_0000;
        endcase
      end
    end

    // ----------------------------------------
    // Command execution
    // ----------------------------------------
    case (s.fsm)
      S_IDLE: ;
      S_EXEC: begin
        // Every command ends here except a parameter fetch
        next_s.fsm  = S_IDLE;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        case (s.code)
          `CMD_STAT_RD: begin
            if (s.dnum == `DNUM_FB) begin
              next_s.rdata = s.fb_cnt;
              next_s.rtype = `TYPE_DEC;
              next_s.rdp   = `DP_NONE;
              next_s.rdis  = 1'b0;
            end else begin
              next_s.err = 1'b1;
            end
          end
          `CMD_STAT_CLR: begin
            // Any other key leaves the count alone
            if (s.dnum == `DNUM_CLR && s.wdata == `CLR_KEY) begin
              fb_clear = 1'b1;
            end else begin
              next_s.err = 1'b1;
            end
          end
          `CMD_PARAM_RD: begin
            if (param_ok(s.dnum)) begin
              next_s.fsm  = S_FETCH;
              next_s.busy = 1'b1;
              next_s.done = 1'b0;
            end else begin
              next_s.err = 1'b1;
            end
          end
          `CMD_PARAM_WR: begin
            if (!param_ok(s.dnum)) begin
              next_s.err = 1'b1;
            end else if (wmode != `WMODE_EE && wmode != `WMODE_RAM) begin
              next_s.err = 1'b1;
            end else if (wdp > `DP_MAX) begin
              next_s.err = 1'b1;
            end else if (param_hex(s.dnum[6:0]) != (wdp == `DP_NONE)) begin
              // Decimal without point, or hex with a point, is refused
              next_s.err = 1'b1;
            end else begin
              next_s.st_we   = 1'b1;
              next_s.st_addr = s.dnum[6:0];
              next_s.st_word = {wdp, 8'h00, s.wdata[`F_VAL]};
              if (wmode == `WMODE_EE) begin
                // Wear count of the nonvolatile copy; RAM mode spares it
                next_s.ee_cnt = s.ee_cnt + 32'h0000_0001;
              end
            end
          end
          `CMD_PIN_RD: begin
            // Pins lag the pads by the two synchroniser stages
            next_s.rtype = `TYPE_HEX;
            next_s.rdp   = `DP_NONE;
            next_s.rdis  = 1'b0;
            if (s.dnum == `DNUM_IN) begin
              next_s.rdata = in_word;
            end else if (s.dnum == `DNUM_OUT) begin
              next_s.rdata = out_word;
            end else begin
              next_s.err = 1'b1;
            end
          end
          default: next_s.err = 1'b1;
        endcase
      end
      S_FETCH: begin
        // Memory word was registered during the execute cycle
        next_s.fsm  = S_IDLE;
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.rdp  = st_rword[`F_ST_DP];
        if (param_hex(s.dnum[6:0])) begin
          next_s.rtype = `TYPE_HEX;
        end else begin
          next_s.rtype = `TYPE_DEC;
        end
        // Parameter 19 itself stays readable so the lock can be undone
        if (lock_word[`F_LOCK] != 4'h0 && s.dnum[6:0] != `INHIBIT_PARAM) begin
          next_s.rdis  = 1'b1;
          next_s.rdata = 32'h0000_0000;
        end else begin
          next_s.rdis  = 1'b0;
          next_s.rdata = {8'h00, st_rword[`F_VAL]};
        end
      end
      default: begin
        next_s.fsm  = S_IDLE;
        next_s.busy = 1'b0;
      end
    endcase

    // ----------------------------------------
    // Feedback pulse counter
    // ----------------------------------------
    // A pulse in the clearing cycle still counts
    if (fb_clear) begin
      next_s.fb_cnt = {31'h0, fb_edge};
    end else if (fb_edge) begin
      next_s.fb_cnt = s.fb_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '{fsm: S_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign DAT_O = s.dat;
  assign ACK_O = s.ack;
endmodule

// File: test/servo_cmd_handler_sva.sv
// Assertions on the command handler's bus handshake and reply fields
`include "servo_cfg.svh"
module servo_cmd_handler_sva
  import servo_pkg::*;
(
  input wire logic                 SYS_CLK,
  input wire logic                 NRST,
  input wire logic                 CYC_I,
  input wire logic                 STB_I,
  input wire logic                 WE_I,
  input wire logic [7:0]           ADR_I,
  input wire logic [3:0]           SEL_I,
  input wire logic [31:0]          DAT_I,
  input wire logic [31:0]          DAT_O,
  input wire logic                 ACK_O,
  input wire logic [`IN_PINS-1:0]  IN_PIN,
  input wire logic [`OUT_PINS-1:0] OUT_PIN,
  input wire logic                 FB_PULSE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ----------------
  // Last command taken, so reply fields can be judged
  // ----------------
  logic [15:0] last;
  wire         take = CYC_I && STB_I && !ACK_O;
  wire [7:0]   cd   = last[15:8];
  wire [7:0]   dn   = last[7:0];
  wire         pin  = cd == `CMD_PIN_RD;
  wire         bad  = (cd == `CMD_PARAM_RD || cd == `CMD_PARAM_WR) ? dn > `DNUM_PMAX :
                      pin ? !(dn == `DNUM_IN || dn == `DNUM_OUT) :
                      !((cd == `CMD_STAT_RD && dn == `DNUM_FB) ||
                        (cd == `CMD_STAT_CLR && dn == `DNUM_CLR));
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) last <= 16'h0000;
    else if (take && WE_I && ADR_I == `A_CMD) last <= DAT_I[15:0];
  end
  sequence s_rd(logic [7:0] a);
    take && !WE_I && ADR_I == a;
  endsequence
  chk_ack_follows: assert property (take |=> ACK_O)
    else $error("no ack after request");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  chk_unmapped_zero: assert property (take && !WE_I && ADR_I > `A_EE_WRITES |=> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  chk_in_bits_zero: assert property (s_rd(`A_RDATA) ##0 pin && dn == `DNUM_IN
    |=> DAT_O[31:`IN_PINS] == '0) else $error("input word high bits set");
  chk_out_bits_zero: assert property (s_rd(`A_RDATA) ##0 pin && dn == `DNUM_OUT
    |=> DAT_O[31:`OUT_PINS] == '0) else $error("output word high bits set");
  chk_pin_type_hex: assert property (s_rd(`A_RINFO) ##0 pin && !bad
    |=> DAT_O[`F_RI_TYPE] == `TYPE_HEX) else $error("pin reply not hex type");
  chk_stat_type_dec: assert property (s_rd(`A_RINFO) ##0 cd == `CMD_STAT_RD && !bad
    |=> DAT_O[`F_RI_TYPE] == `TYPE_DEC && DAT_O[`F_RI_DP] == `DP_NONE)
    else $error("status reply format wrong");
  chk_bad_cmd_err: assert property (s_rd(`A_STATUS) ##0 bad
    |=> !DAT_O[`B_DONE] || DAT_O[`B_ERR]) else $error("bad command without error");
endmodule

// File: test/io_world.sv
// Model of the pins around the amplifier: inputs, outputs, feedback pulses
`include "servo_cfg.svh"
module io_world (
  input  wire logic                 clk,
  output logic      [`IN_PINS-1:0]  in_pin,
  output logic      [`OUT_PINS-1:0] out_pin,
  output logic                      fb
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    in_pin = '0;
    out_pin = '0;
    fb = 1'b0;
  end
  task automatic set_pins(input logic [`IN_PINS-1:0] i, input logic [`OUT_PINS-1:0] o);
    @(posedge clk);
    in_pin <= i;
    out_pin <= o;
  endtask
  // Low for two cycles so the synchroniser never merges two pulses
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      fb <= 1'b1;
      @(posedge clk);
      fb <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule

// File: test/servo_cmd_handler_test.sv
// Self-checking bench for the servo serial command handler
`include "servo_cfg.svh"
module servo_cmd_handler_test
  import servo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, fb;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dati = 32'h0, dato, rd, st, v;
  logic [8:0]  in_pin;
  logic [6:0]  out_pin;
  logic [7:0]  p;
  logic [31:0] bad [3] = '{32'h3000_0777, 32'h5200_0777, 32'h3600_0777};
  int          error_cnt = 0, n_checks = 0, n;
  always #20 clk = ~clk;
  io_world io (.clk(clk), .in_pin(in_pin), .out_pin(out_pin), .fb(fb));
  servo_cmd_handler dut (.SYS_CLK(clk), .NRST(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dati), .DAT_O(dato), .ACK_O(ack), .IN_PIN(in_pin),
    .OUT_PIN(out_pin), .FB_PULSE(fb));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Pin word expected: only the low w positions carry pins
  function automatic logic [31:0] pin_exp(input logic [31:0] raw, input int w);
    return raw & ((32'h0000_0001 << w) - 32'h0000_0001);
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      results();
    end else begin
      rd = dato;
    end
  endtask
  task automatic cmd(input logic [15:0] c, input logic [31:0] d, input logic e);
    int i = 0;
    wb(1, `A_WDATA, d);
    wb(1, `A_CMD, {16'h0, c});
    do begin
      wb(0, `A_STATUS, 0);
      i++;
    end while (rd[`B_DONE] !== 1'b1 && i < 10);
    if (rd[`B_DONE] !== 1'b1) begin
      error_cnt++;
      results();
    end else begin
      chk("status", rd[2:0], {e, 2'b10});
    end
  endtask
  task automatic rdpar(input logic [7:0] a, input logic [23:0] x, input logic [3:0] dp, t,
                       input logic dis);
    cmd({`CMD_PARAM_RD, a}, 0, 0);
    wb(0, `A_RDATA, 0);
    chk("param value", rd, dis ? 32'h0 : {8'h0, x});
    wb(0, `A_RINFO, 0);
    chk("param info", rd[8:0], {dis, t, dp});
  endtask
  initial begin
    void'($urandom(32'h0a7dd2bd));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wb(0, `A_STATUS, 0);
    chk("status reset", rd, 0);
    wb(1, 8'h18, 32'hFFFF_FFFF);
    wb(0, 8'h18, 0);
    chk("unmapped", rd, 0);
    sel <= 4'h5;
    wb(1, `A_WDATA, 32'hAABB_CCDD);
    sel <= 4'hF;
    wb(0, `A_WDATA, 0);
    chk("lane merge", rd, 32'h00BB_00DD);
    $display("test reset done");
    repeat (4) begin
      v = $urandom;
      io.set_pins(v[8:0], v[15:9]);
      repeat (4) @(posedge clk);
      cmd({`CMD_PIN_RD, `DNUM_IN}, 0, 0);
      wb(0, `A_RDATA, 0);
      chk("in pins", rd, pin_exp(v, `IN_PINS));
      cmd({`CMD_PIN_RD, `DNUM_OUT}, 0, 0);
      wb(0, `A_RDATA, 0);
      chk("out pins", rd, pin_exp(v >> `IN_PINS, `OUT_PINS));
      wb(0, `A_RINFO, 0);
      chk("pin type", rd[7:4], `TYPE_HEX);
    end
    cmd({`CMD_PIN_RD, 8'h41}, 0, 1);
    $display("test pins done");
    n = $urandom_range(9, 1);
    io.pulses(n);
    repeat (4) @(posedge clk);
    cmd({`CMD_STAT_CLR, `DNUM_CLR}, 32'h0000_1EA4, 1);
    cmd({`CMD_STAT_RD, 8'h00}, 0, 1);
    cmd({`CMD_STAT_RD, `DNUM_FB}, 0, 0);
    wb(0, `A_RDATA, 0);
    chk("fb count", rd, n);
    wb(0, `A_RINFO, 0);
    chk("fb info", rd[7:0], 0);
    cmd({`CMD_STAT_CLR, `DNUM_CLR}, `CLR_KEY, 0);
    cmd({`CMD_STAT_RD, `DNUM_FB}, 0, 0);
    wb(0, `A_RDATA, 0);
    chk("fb cleared", rd, 0);
    $display("test feedback done");
    // Values stay inside 24 bits and legal point positions
    repeat (6) begin
      p = 8'($urandom_range(84, 2));
      if (p == 8'h13) p = 8'h14;
      v = {4'h3, 4'($urandom_range(5, 1)), 24'($urandom)};
      cmd({`CMD_PARAM_WR, p}, v, 0);
      rdpar(p, v[23:0], v[27:24], `TYPE_DEC, 0);
    end
    v = {8'h00, 24'($urandom)};
    cmd({`CMD_PARAM_WR, 8'h00}, v, 0);
    wb(0, `A_EE_WRITES, 0);
    chk("eeprom writes", rd, 1);
    rdpar(8'h00, v[23:0], 0, `TYPE_HEX, 0);
    cmd({`CMD_PARAM_WR, 8'h20}, 32'h3200_0123, 0);
    foreach (bad[i]) cmd({`CMD_PARAM_WR, 8'h20}, bad[i], 1);
    cmd({`CMD_PARAM_WR, 8'h00}, 32'h0100_0001, 1);
    cmd({`CMD_PARAM_WR, 8'h55}, 32'h3100_0001, 1);
    cmd({`CMD_PARAM_RD, 8'h55}, 0, 1);
    cmd(16'h7700, 0, 1);
    rdpar(8'h20, 24'h000123, 4'h2, `TYPE_DEC, 0);
    cmd({`CMD_PARAM_WR, `DNUM_PMAX}, 32'h3100_0042, 0);
    rdpar(`DNUM_PMAX, 24'h000042, 4'h1, `TYPE_DEC, 0);
    $display("test params done");
    cmd({`CMD_PARAM_WR, 8'h13}, 32'h3000_0001, 0);
    rdpar(8'h20, 24'h000123, 4'h2, `TYPE_DEC, 1);
    rdpar(8'h13, 24'h000001, 0, `TYPE_HEX, 0);
    cmd({`CMD_PARAM_WR, 8'h13}, 32'h3000_0000, 0);
    rdpar(8'h20, 24'h000123, 4'h2, `TYPE_DEC, 0);
    $display("test lock done");
    results();
  end
endmodule
bind servo_cmd_handler servo_cmd_handler_sva chk_i (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .IN_PIN(IN_PIN), .OUT_PIN(OUT_PIN), .FB_PULSE(FB_PULSE));
